// File: include/system_option_flag_command_regs_defines.svh
`ifndef SYSTEM_OPTION_FLAG_COMMAND_REGS_DEFINES_SVH
`define SYSTEM_OPTION_FLAG_COMMAND_REGS_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_OPTION       10'h094
`define IDX_FLAGS        10'h095
`define IDX_WAKE         10'h096
`define IDX_COMMAND      10'h097
`define IDX_IRQ_STATUS   10'h0A0
`define IDX_IRQ_CLEAR    10'h0A1
`define IDX_IRQ_ENABLE   10'h0A2

// Field positions
`define OPT_SERIAL_BIT   7
`define FLG_LOWV_BIT     7
`define FLG_TOUCH_BIT    5
`define FLG_CONV_BIT     4
`define FLG_PORT1_BIT    1
`define FLG_TICK_BIT     0
`define OPT_WRITE_MASK   8'hBF
`define FLG_USED_MASK    8'hB3

// Reset values
`define OPTION_RESET     8'h00
`define WAKE_RESET       8'h00
`define PORT1_IDLE       8'hFF

// Command codes
`define CMD_SOFT_RESET   8'h56
`define CMD_PROG_ENABLE  8'h65

// Watchdog periods in ms
`define WDT_MS_00        10'd480
`define WDT_MS_01        10'd240
`define WDT_MS_10        10'd120
`define WDT_MS_11        10'd60

// Converter clock divisors
`define ADC_DIV_00       6'd32
`define ADC_DIV_01       6'd16
`define ADC_DIV_10       6'd8
`define ADC_DIV_11       6'd4

// Tick periods in slow clock cycles
`define TICK_00          17'd32768
`define TICK_01          17'd16384
`define TICK_10          17'd8192
`define TICK_11          17'd128

`endif

// File: include/system_option_flag_command_regs_pkg.sv
package system_option_flag_command_regs_pkg;

  // Whole state of the register bank
  typedef struct packed {
    logic [7:0]  option;
    logic [7:0]  flags;
    logic [7:0]  wake;
    logic        prog_enable;
    logic [7:0]  irq_status;
    logic [7:0]  irq_enable;
    logic        irq;
    logic        lv_s1;
    logic        lv_s2;
    logic [7:0]  p1_s1;
    logic [7:0]  p1_s2;
    logic [7:0]  p1_prev;
    logic        p1_valid;
    logic        slow_s1;
    logic        slow_s2;
    logic        slow_prev;
    logic [16:0] tick_count;
    logic [5:0]  adc_count;
    logic        adc_tick;
    logic        soft_reset;
    logic [9:0]  wdt_ms;
    logic [1:0]  prog_area;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } regs_s;

endpackage

// File: rtl/system_option_flag_command_regs.sv
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "system_option_flag_command_regs_defines.svh"

module system_option_flag_command_regs
  import system_option_flag_command_regs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        low_voltage_detect,
  input  wire logic        touch_conversion_done,
  input  wire logic        touch_conversion_start,
  input  wire logic        sysclk_fast_enough,
  input  wire logic        converter_done,
  input  wire logic        converter_start,
  input  wire logic [7:0]  port1_pins,
  input  wire logic        port1_isr_enter,
  input  wire logic        tick_isr_enter,
  input  wire logic        slow_clock,
  input  wire logic        watchdog_timeout_flag,
  input  wire logic [1:0]  memory_lock_setting,
  output logic             single_wire_serial_select,
  output logic      [1:0]  watchdog_period_select,
  output logic      [9:0]  watchdog_period_ms,
  output logic             converter_clock_tick,
  output logic      [7:0]  port1_wake_enable,
  output logic             soft_reset_command,
  output logic             self_program_enable,
  output logic      [1:0]  self_program_area
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Converter divisor for a code
  function automatic logic [5:0] adc_divisor(input logic [1:0] code);
    logic [5:0] d;
    d = `ADC_DIV_00;
    case (code)
      2'b01: d = `ADC_DIV_01;
      2'b10: d = `ADC_DIV_10;
      2'b11: d = `ADC_DIV_11;
      default: d = `ADC_DIV_00;
    endcase
    return d;
  endfunction

  // Tick period in slow cycles for a code
  function automatic logic [16:0] tick_period(input logic [1:0] code);
    logic [16:0] p;
    p = `TICK_00;
    case (code)
      2'b01: p = `TICK_01;
      2'b10: p = `TICK_10;
      2'b11: p = `TICK_11;
      default: p = `TICK_00;
    endcase
    return p;
  endfunction

  // Watchdog period in ms for a code
  function automatic logic [9:0] wdt_period(input logic [1:0] code);
    logic [9:0] m;
    m = `WDT_MS_00;
    case (code)
      2'b01: m = `WDT_MS_01;
      2'b10: m = `WDT_MS_10;
      2'b11: m = `WDT_MS_11;
      default: m = `WDT_MS_00;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------

  regs_s       s;
  regs_s       next_s;
  logic [9:0]  idx;
  logic        setup;
  logic        wr;
  logic [7:0]  wdat;
  logic        wr_flags;
  logic        wr_cmd;
  logic [7:0]  rdat;
  logic        mapped;
  logic        slow_edge;
  logic        tick_hit;
  logic [7:0]  pin_change;
  logic [7:0]  events;
  logic        set_touch;
  logic        set_conv;
  logic        set_port1;
  logic        clr_touch;
  logic        clr_conv;
  logic        clr_port1;
  logic        clr_tick;
  logic        adc_hit;

  // Next state of the whole bank
  always_comb
  begin
    next_s = s;
    idx = paddr[11:2];
    setup = psel & ~penable;
    // Access takes effect only on the edge where pready is seen high
    wr = psel & penable & s.pready & pwrite;
    wdat = pwdata[7:0];
    wr_flags = wr & (idx == `IDX_FLAGS);
    wr_cmd = wr & (idx == `IDX_COMMAND);

    // Two-flop synchronisers for pin inputs
    next_s.lv_s1 = low_voltage_detect;
    next_s.lv_s2 = s.lv_s1;
    next_s.p1_s1 = port1_pins;
    next_s.p1_s2 = s.p1_s1;
    next_s.p1_prev = s.p1_s2;
    next_s.p1_valid = 1'b1;
    next_s.slow_s1 = slow_clock;
    next_s.slow_s2 = s.slow_s1;
    next_s.slow_prev = s.slow_s2;

    // Tick timer on slow clock rising edges
    slow_edge = s.slow_s2 & ~s.slow_prev;
    tick_hit = slow_edge & ((s.tick_count + 17'd1) >= tick_period(s.option[1:0]));
    if (slow_edge)
    begin
      next_s.tick_count = tick_hit ? 17'd0 : s.tick_count + 17'd1;
    end

    // Converter clock divider; >= so a code change never overruns
    adc_hit = (s.adc_count + 6'd1) >= adc_divisor(s.option[3:2]);
    next_s.adc_count = adc_hit ? 6'd0 : s.adc_count + 6'd1;
    next_s.adc_tick = adc_hit;

    // Port 1 change, gated by the per-pin wake enables and by p1_valid
    pin_change = (s.p1_s2 ^ s.p1_prev) & s.wake & {8{s.p1_valid}};

    // Flag set and clear terms; set wins over clear
    set_touch = touch_conversion_done & sysclk_fast_enough;
    set_conv = converter_done;
    set_port1 = |pin_change;
    clr_touch = (wr_flags & ~wdat[`FLG_TOUCH_BIT]) | touch_conversion_start;
    clr_conv = (wr_flags & ~wdat[`FLG_CONV_BIT]) | converter_start;
    clr_port1 = (wr_flags & ~wdat[`FLG_PORT1_BIT]) | port1_isr_enter;
    clr_tick = (wr_flags & ~wdat[`FLG_TICK_BIT]) | tick_isr_enter;
    next_s.flags = 8'h00;
    next_s.flags[`FLG_LOWV_BIT] = s.lv_s2;
    next_s.flags[`FLG_TOUCH_BIT] = set_touch | (s.flags[`FLG_TOUCH_BIT] & ~clr_touch);
    next_s.flags[`FLG_CONV_BIT] = set_conv | (s.flags[`FLG_CONV_BIT] & ~clr_conv);
    next_s.flags[`FLG_PORT1_BIT] = set_port1 | (s.flags[`FLG_PORT1_BIT] & ~clr_port1);
    next_s.flags[`FLG_TICK_BIT] = tick_hit | (s.flags[`FLG_TICK_BIT] & ~clr_tick);

    // Interrupt events share the flag layout; low voltage on its rising edge
    events = 8'h00;
    events[`FLG_LOWV_BIT] = s.lv_s2 & ~s.flags[`FLG_LOWV_BIT];
    events[`FLG_TOUCH_BIT] = set_touch;
    events[`FLG_CONV_BIT] = set_conv;
    events[`FLG_PORT1_BIT] = set_port1;
    events[`FLG_TICK_BIT] = tick_hit;
    if (wr && (idx == `IDX_IRQ_CLEAR))
    begin
      next_s.irq_status = events | (s.irq_status & ~wdat);
    end
    else
    begin
      next_s.irq_status = events | s.irq_status;
    end
    next_s.irq = |(s.irq_status & s.irq_enable);

    // Register writes
    next_s.soft_reset = 1'b0;
    if (wr && (idx == `IDX_OPTION))
    begin
      next_s.option = wdat & `OPT_WRITE_MASK;
    end
    else if (wr && (idx == `IDX_WAKE))
    begin
      next_s.wake = wdat;
    end
    else if (wr && (idx == `IDX_IRQ_ENABLE))
    begin
      next_s.irq_enable = wdat & `FLG_USED_MASK;
    end
    else if (wr_cmd)
    begin
      next_s.soft_reset = (wdat == `CMD_SOFT_RESET);
      next_s.prog_enable = (wdat == `CMD_PROG_ENABLE);
    end

    // Derived outputs held in flops
    next_s.wdt_ms = wdt_period(s.option[5:4]);
    next_s.prog_area = s.prog_enable ? memory_lock_setting : 2'b00;

    // Read mux; unmapped answers zero with an error
    mapped = 1'b1;
    rdat = 8'h00;
    if (idx == `IDX_OPTION)
    begin
      rdat = s.option;
    end
    else if (idx == `IDX_FLAGS)
    begin
      rdat = s.flags;
    end
    else if (idx == `IDX_WAKE)
    begin
      rdat = s.wake;
    end
    else if (idx == `IDX_COMMAND)
    begin
      rdat = {6'b000000, watchdog_timeout_flag, s.prog_enable};
    end
    else if (idx == `IDX_IRQ_STATUS)
    begin
      rdat = s.irq_status;
    end
    else if (idx == `IDX_IRQ_CLEAR)
    begin
      rdat = 8'h00;
    end
    else if (idx == `IDX_IRQ_ENABLE)
    begin
      rdat = s.irq_enable;
    end
    else
    begin
      mapped = 1'b0;
    end

    // Zero-wait answer: prepared in setup, shown for the one access cycle
    next_s.pready = setup;
    next_s.pslverr = setup & ~mapped;
    next_s.prdata = (setup & ~pwrite) ? {24'h000000, rdat} : 32'h00000000;
  end

  // Register the whole state
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.option <= `OPTION_RESET;
      s.wake <= `WAKE_RESET;
      s.wdt_ms <= `WDT_MS_00;
      // Port sampler starts at the idle high level, so no false edge after reset
      s.p1_s1 <= `PORT1_IDLE;
      s.p1_s2 <= `PORT1_IDLE;
      s.p1_prev <= `PORT1_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from a flop
  // ----------------------------------------------------------------

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign single_wire_serial_select = s.option[`OPT_SERIAL_BIT];
  assign watchdog_period_select = s.option[5:4];
  assign watchdog_period_ms = s.wdt_ms;
  assign converter_clock_tick = s.adc_tick;
  assign port1_wake_enable = s.wake;
  assign soft_reset_command = s.soft_reset;
  assign self_program_enable = s.prog_enable; // software must drop it after use
  assign self_program_area = s.prog_area;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence cmd_write_s(logic [7:0] v);
    wr_cmd && (wdat == v);
  endsequence

  sequence adc_fast_run_s;
    (s.adc_tick && (s.option[3:2] == 2'b11)) ##1 (s.option[3:2] == 2'b11) [*3];
  endsequence

  serial_select_a: assert property (wr && (idx == `IDX_OPTION) |=>
    single_wire_serial_select == $past(pwdata[7]))
    else $error("serial select did not follow write");
  wdt_period_a: assert property ((s.option[5:4] == 2'b11) ##1 (s.option[5:4] == 2'b11)
    |-> watchdog_period_ms == 10'd60)
    else $error("watchdog period wrong");
  adc_div_a: assert property (adc_fast_run_s |=> s.adc_tick)
    else $error("converter clock not divided by four");
  tick_flag_a: assert property (tick_hit |=> s.flags[`FLG_TICK_BIT])
    else $error("tick flag not set");
  port1_set_a: assert property (|pin_change |=> s.flags[`FLG_PORT1_BIT])
    else $error("port1 change flag not set");
  port1_isr_a: assert property (port1_isr_enter && !set_port1 |=>
    !s.flags[`FLG_PORT1_BIT])
    else $error("port1 flag not cleared on service entry");
  conv_clear_a: assert property (converter_start && !converter_done |=>
    !s.flags[`FLG_CONV_BIT])
    else $error("converter flag not cleared by start");
  flag_mask_a: assert property (wr_flags && wdat[`FLG_TOUCH_BIT]
    && !touch_conversion_start |=> s.flags[`FLG_TOUCH_BIT] == $past(s.flags[`FLG_TOUCH_BIT])
    || $past(set_touch))
    else $error("touch flag changed on a one write");
  soft_reset_a: assert property (cmd_write_s(`CMD_SOFT_RESET) |=> soft_reset_command
    ##1 !soft_reset_command)
    else $error("soft reset pulse wrong");
  prog_set_a: assert property (wr_cmd |=> self_program_enable == ($past(wdat) == 8'h65))
    else $error("programming enable wrong after command");
  cmd_read_a: assert property (setup && !pwrite && (idx == `IDX_COMMAND) |=>
    prdata[1:0] == {$past(watchdog_timeout_flag), $past(s.prog_enable)})
    else $error("command readback wrong");

  // Flag sets and clears; each clear is guarded against a same-cycle set
  lowv_readonly_a: assert property (wr_flags |=>
    s.flags[`FLG_LOWV_BIT] == $past(s.lv_s2))
    else $error("low voltage flag changed by a write");
  touch_set_a: assert property (set_touch |=> s.flags[`FLG_TOUCH_BIT])
    else $error("touch flag not set");
  touch_clear_a: assert property (touch_conversion_start && !set_touch |=>
    !s.flags[`FLG_TOUCH_BIT])
    else $error("touch flag not cleared by start");
  conv_set_a: assert property (converter_done |=> s.flags[`FLG_CONV_BIT])
    else $error("converter flag not set");
  port1_write_a: assert property (wr_flags && !wdat[`FLG_PORT1_BIT] && !set_port1 |=>
    !s.flags[`FLG_PORT1_BIT])
    else $error("port1 flag not cleared by write");
  tick_isr_a: assert property (tick_isr_enter && !tick_hit |=>
    !s.flags[`FLG_TICK_BIT])
    else $error("tick flag not cleared on service entry");

  // Register contents and command side effects
  wake_write_a: assert property (wr && (idx == `IDX_WAKE) |=>
    port1_wake_enable == $past(wdat))
    else $error("wake enables did not follow write");
  cmd_other_a: assert property (wr_cmd && (wdat != `CMD_SOFT_RESET) |=>
    !soft_reset_command)
    else $error("soft reset on another command");
  prog_area_a: assert property (s.prog_enable |=>
    self_program_area == $past(memory_lock_setting))
    else $error("programming area wrong");

endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "system_option_flag_command_regs_defines.svh"

module testbench
  import system_option_flag_command_regs_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err, low_voltage_detect, sysclk_fast_enough, slow_clock;
  logic        watchdog_timeout_flag, single_wire_serial_select, converter_clock_tick;
  logic        soft_reset_command, self_program_enable;
  logic [1:0]  memory_lock_setting, watchdog_period_select, self_program_area;
  logic [9:0]  watchdog_period_ms;
  logic [7:0]  port1_pins, port1_wake_enable;
  logic [5:0]  ev;
  logic [9:0]  ms [4] = '{`WDT_MS_00, `WDT_MS_01, `WDT_MS_10, `WDT_MS_11};
  logic [5:0]  dv [4] = '{`ADC_DIV_00, `ADC_DIV_01, `ADC_DIV_10, `ADC_DIV_11};
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          resets_seen = 0;
  localparam int CDONE = 0, CSTART = 1, TDONE = 2, TSTART = 3, P1ISR = 4, TKISR = 5;

  // Event inputs share one vector so a single task can pulse any of them
  system_option_flag_command_regs u_system_option_flag_command_regs (
    .mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .low_voltage_detect, .touch_conversion_done(ev[TDONE]),
    .touch_conversion_start(ev[TSTART]), .sysclk_fast_enough,
    .converter_done(ev[CDONE]), .converter_start(ev[CSTART]), .port1_pins,
    .port1_isr_enter(ev[P1ISR]), .tick_isr_enter(ev[TKISR]), .slow_clock,
    .watchdog_timeout_flag, .memory_lock_setting, .single_wire_serial_select,
    .watchdog_period_select, .watchdog_period_ms, .converter_clock_tick,
    .port1_wake_enable, .soft_reset_command, .self_program_enable, .self_program_area
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  always #10 mclk = ~mclk;

  // Soft reset pulses counted on the falling edge, away from updates
  always @(negedge mclk) if (soft_reset_command === 1'b1) resets_seen++;

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // APB transfer; answer taken at the rising edge where pready is seen high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No wait count assumed; only the hang guard ends a stuck access
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
  endtask

  task automatic rdreg(input logic [9:0] idx);
    apb(1'b0, idx, 32'h0);
  endtask

  task automatic pass(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic pulse(input int which);
    @(posedge mclk);
    ev[which] <= 1'b1;
    @(posedge mclk);
    ev <= 6'h00;
  endtask

  task automatic flag_is(input int b, input logic v);
    rdreg(`IDX_FLAGS);
    check(rd[b], v);
  endtask

  // Slow clock only runs while a scenario wants tick edges
  task automatic slow(input int n);
    repeat (n)
    begin
      pass(3);
      slow_clock <= 1'b1;
      pass(3);
      slow_clock <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdreg(`IDX_WAKE);
    check(rd, 32'h0);
    rdreg(`IDX_COMMAND);
    check(rd, 32'h0);
    check(watchdog_period_ms, `WDT_MS_00);
  endtask

  // Every code of the three option fields, divider period measured
  task automatic t_option();
    logic [1:0] k;
    logic [7:0] opt;
    int         n;
    for (int c = 0; c < 4; c++)
    begin
      k = c[1:0];
      opt = {k[0], 1'b0, k, k, 2'b00};
      wr(`IDX_OPTION, opt);
      rdreg(`IDX_OPTION);
      check(rd, {24'h0, opt});
      check(single_wire_serial_select, k[0]);
      check(watchdog_period_select, k);
      check(watchdog_period_ms, ms[k]);
      pass(40);
      @(negedge mclk);
      n = 0;
      while (converter_clock_tick !== 1'b1 && n < 100)
      begin
        @(negedge mclk);
        n++;
      end
      n = 0;
      do
      begin
        @(negedge mclk);
        n++;
      end
      while (converter_clock_tick !== 1'b1 && n < 100);
      check(n, dv[k]);
    end
  endtask

  // Shortest tick rate: flag must wait for exactly the last edge
  task automatic t_tick();
    wr(`IDX_OPTION, 8'hFF);
    rdreg(`IDX_OPTION);
    check(rd, 32'hBF);
    slow(`TICK_11 - 1);
    pass(8);
    flag_is(0, 1'b0);
    slow(1);
    pass(8);
    flag_is(0, 1'b1);
    pulse(TKISR);
    flag_is(0, 1'b0);
    slow(`TICK_11);
    pass(8);
    flag_is(0, 1'b1);
    wr(`IDX_FLAGS, 8'hFE);
    flag_is(0, 1'b0);
  endtask

  task automatic t_conv_touch();
    pulse(TDONE);
    flag_is(5, 1'b0);
    @(posedge mclk);
    sysclk_fast_enough <= 1'b1;
    pulse(CDONE);
    pulse(TDONE);
    rdreg(`IDX_FLAGS);
    check(rd[5:4], 2'b11);
    wr(`IDX_FLAGS, 8'hFF);
    rdreg(`IDX_FLAGS);
    check(rd[5:4], 2'b11);
    wr(`IDX_FLAGS, 8'hEF);
    rdreg(`IDX_FLAGS);
    check(rd[5:4], 2'b10);
    wr(`IDX_FLAGS, 8'hDF);
    rdreg(`IDX_FLAGS);
    check(rd[5:4], 2'b00);
    pulse(CDONE);
    pulse(TDONE);
    pulse(CSTART);
    rdreg(`IDX_FLAGS);
    check(rd[5:4], 2'b10);
    pulse(TSTART);
    rdreg(`IDX_FLAGS);
    check(rd[5:4], 2'b00);
  endtask

  task automatic t_lowv();
    @(posedge mclk);
    low_voltage_detect <= 1'b1;
    pass(5);
    flag_is(7, 1'b1);
    wr(`IDX_FLAGS, 8'h00);
    flag_is(7, 1'b1);
    low_voltage_detect <= 1'b0;
    pass(5);
    flag_is(7, 1'b0);
  endtask

  // Pin 0 is not wake-enabled, pin 2 is
  task automatic t_port1();
    wr(`IDX_WAKE, 8'h04);
    pass(1);
    check(port1_wake_enable, 8'h04);
    wr(`IDX_FLAGS, 8'hFD);
    port1_pins <= 8'hFE;
    pass(6);
    flag_is(1, 1'b0);
    port1_pins <= 8'hFA;
    pass(6);
    flag_is(1, 1'b1);
    pulse(P1ISR);
    flag_is(1, 1'b0);
    port1_pins <= 8'hFE;
    pass(6);
    flag_is(1, 1'b1);
    wr(`IDX_FLAGS, 8'hFD);
    flag_is(1, 1'b0);
  endtask

  task automatic t_command();
    watchdog_timeout_flag <= 1'b1;
    memory_lock_setting <= 2'b10;
    wr(`IDX_COMMAND, `CMD_PROG_ENABLE);
    pass(2);
    check(self_program_enable, 1'b1);
    check(self_program_area, 2'b10);
    rdreg(`IDX_COMMAND);
    check(rd, 32'h3);
    check(resets_seen, 0);
    wr(`IDX_COMMAND, `CMD_SOFT_RESET);
    pass(3);
    check(resets_seen, 1);
    check(soft_reset_command, 1'b0);
    check(self_program_enable, 1'b0);
    rdreg(`IDX_COMMAND);
    check(rd, 32'h2);
  endtask

  // Masked event, then enable, clear, and an unmapped access
  task automatic t_irq();
    wr(`IDX_IRQ_CLEAR, 8'hFF);
    pulse(CDONE);
    pass(3);
    check(irq, 1'b0);
    rdreg(`IDX_IRQ_STATUS);
    check(rd[4], 1'b1);
    wr(`IDX_IRQ_ENABLE, 8'h10);
    pass(3);
    check(irq, 1'b1);
    wr(`IDX_IRQ_CLEAR, 8'h10);
    pass(3);
    check(irq, 1'b0);
    rdreg(10'h3FF);
    check({err, rd[30:0]}, 32'h80000000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {low_voltage_detect, sysclk_fast_enough, slow_clock, watchdog_timeout_flag} = '0;
    memory_lock_setting = 2'b00;
    port1_pins = 8'hFF;
    ev = 6'h00;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_option();
    t_tick();
    t_conv_touch();
    t_lowv();
    t_port1();
    t_command();
    t_irq();
    tally_and_finish();
  end
endmodule
